// ==== design/uai_pkg.sv ====
// Constants, register map and carrier types for the serial port interrupt/baud/mode block.
// Assumes the FIFO, line control and shifter logic live outside and share this clock.
package uai_pkg;
    localparam logic [7:0]  ISR_OFS    = 8'h1c;
    localparam logic [7:0]  TOR_OFS    = 8'h20;
    localparam logic [7:0]  BAUD_OFS   = 8'h24;
    localparam logic [7:0]  IRCR_OFS   = 8'h28;
    localparam logic [7:0]  ALT_OFS    = 8'h2c;
    localparam logic [7:0]  FUN_OFS    = 8'h30;
    localparam logic [7:0]  AUX_OFS    = 8'h34;
    localparam logic [31:0] TOR_MASK   = 32'h0000ffff;
    localparam logic [31:0] BAUD_MASK  = 32'h3f00ffff;
    localparam logic [31:0] IRCR_MASK  = 32'h00000062;
    localparam logic [31:0] ALT_MASK   = 32'hff0087cf;
    localparam logic [31:0] FUN_MASK   = 32'h00000003;
    localparam logic [31:0] TOR_RST    = 32'h00000000;
    localparam logic [31:0] BAUD_RST   = 32'h0f000000;
    localparam logic [31:0] IRCR_RST   = 32'h00000040;
    localparam logic [31:0] ALT_RST    = 32'h00000000;
    localparam logic [31:0] FUN_RST    = 32'h00000000;
    localparam int TOR_DLY_LSB   = 8;
    localparam int BAUD_XEN_BIT  = 29;
    localparam int BAUD_XONE_BIT = 28;
    localparam int BAUD_X_LSB    = 24;
    localparam int IRCR_INVRX    = 6;
    localparam int IRCR_INVTX    = 5;
    localparam int IRCR_TXSEL    = 1;
    localparam int ALT_MATCH_LSB = 24;
    localparam int ALT_ADDEN     = 15;
    localparam int ALT_AUD       = 10;
    localparam int ALT_AAD       = 9;
    localparam int ALT_NMM       = 8;
    localparam int ALT_LINTX     = 7;
    localparam int ALT_LINRX     = 6;
    localparam int ISR_LIN       = 7;
    localparam int AUX_CTS       = 0;
    localparam int AUX_TXOVR     = 1;
    localparam int AUX_ADDR      = 2;
    localparam int AUX_TOCNT_LSB = 8;
    localparam logic        THRE_RST     = 1'b1;
    localparam logic [3:0]  M_DEFAULT_M1 = 4'hf;
    localparam logic [4:0]  LIN_BRK_ADD  = 5'd2;
    localparam logic [16:0] BRD_ADD      = 17'd2;

    typedef enum logic [1:0] {
        UAI_FN_UART  = 2'b00,
        UAI_FN_LIN   = 2'b01,
        UAI_FN_IRDA  = 2'b10,
        UAI_FN_RS485 = 2'b11
    } uai_func_t;

    typedef enum logic [1:0] {
        UAI_LT_IDLE  = 2'b00,
        UAI_LT_ALIGN = 2'b01,
        UAI_LT_SEND  = 2'b11
    } uai_lin_st_t;

    typedef struct packed {
        logic rx_push;
        logic rx_pop;
        logic tx_write;
        logic tx_last_moved;
        logic tx_stop_done;
        logic lin_break_seen;
        logic addr_char;
    } uai_evt_t;

    typedef struct packed {
        logic brk;
        logic frame;
        logic parity;
        logic rx_over;
    } uai_line_t;

    typedef struct packed {
        logic lin;
        logic buf_err;
        logic tout;
        logic modem;
        logic rls;
        logic thre;
        logic rda;
    } uai_ien_t;
endpackage

// ==== design/uai_ctrl.sv ====
// Interrupt status, receive time-out, baud generator, IrDA/LIN/RS-485 mode control.
// Assumes FIFO/shifter events arrive as one-cycle pulses on clk_i; pins are asynchronous.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Each interrupt indicator reads one only while its flag and enable are one.
// - LIN break detected sets a flag, interrupts if enabled, write one clears.
// - Buffer error follows either overflow flag, read-only, clears when both clear.
// - Time-out flag sets when data waits idle and counter hits compare; buffer read clears.
// - Time-out counter ticks per bit, restarts on new word; new data or empty clears.
// - Modem flag mirrors the clear-to-send change flag.
// - Line status flag is set by break, frame, parity or address detect; read-only.
// - RS-485 address character sets line status and the address detect flag.
// - Holding-empty flag sets when last entry leaves, clears on a new write.
// - Receive-available flag sets when FIFO count equals trigger level.
// - Transmitter idles a programmable gap between stop bit and next start.
// - Bit rate is clock divided by M times divisor plus two; M defaults sixteen.
// - With extra divider on, M is field plus one unless BAUD_XONE_BIT forces it to one; software keeps it at least eight.
// - Two bits independently invert receive input and transmit output.
// - IrDA direction bit: zero enables receiver, one enables transmitter.
// - Hold an 8-bit address match value and an address detect enable.
// - LIN transmit-break enable sends a break, then hardware clears the bit.
// - The transmitted break lasts break length field plus two bit times.
// - Function select picks plain, LIN, IrDA or RS-485 mode.
// - Writing while transmit FIFO is full sets overflow; write one clears.
// - Clear-to-send change flag sets on any input change; write one clears.
module uai_ctrl #(
    parameter int CNT_W = 5
) (
    input  wire logic                 clk_i,                 // 200 MHz clock
    input  wire logic                 reset_n_i,             // Async reset, active low
    input  wire logic [7:0]           addr_i,                // Register byte address
    input  wire logic [31:0]          wdata_i,               // Write data
    input  wire logic                 wr_i,                  // Write strobe
    input  wire logic                 rd_i,                  // Read strobe
    output logic      [31:0]          rdata_o,               // Read data, cycle after rd_i
    input  wire uai_pkg::uai_evt_t    evt_i,                 // FIFO and shifter event pulses
    input  wire uai_pkg::uai_line_t   line_i,                // Receive error flag levels
    input  wire uai_pkg::uai_ien_t    ien_i,                 // Interrupt enables
    input  wire logic [CNT_W-1:0]     rx_count_i,            // Words in receive FIFO
    input  wire logic [CNT_W-1:0]     rx_trigger_level_i,    // Receive trigger level
    input  wire logic                 tx_fifo_full_i,        // Transmit FIFO full
    input  wire logic                 rx_buffer_port_rd_i,   // Receive buffer read pulse
    input  wire logic [7:0]           rx_addr_data_i,        // Address character value
    input  wire logic                 cts_pin_i,             // Clear-to-send pin
    input  wire logic                 rx_pin_i,              // Receive pin
    input  wire logic                 tx_serial_i,           // Shifter serial output
    output logic                      rx_serial_o,           // Synced, maybe inverted rx
    output logic                      tx_pin_o,              // Transmit pin
    output logic                      baud_tick_o,           // One pulse per bit time
    output logic                      tx_gap_hold_o,         // Holds next start bit back
    output logic                      irda_tx_enable_o,      // IrDA transmit path on
    output logic                      irda_rx_enable_o,      // IrDA receive path on
    output logic      [1:0]           controller_function_select_o // Active mode
);
    logic [31:0] tor, baud, ircr, alt, fun;
    logic        rx_avail_flag, tx_hold_empty_flag, tout_flag, lin_flag;
    logic        cts_change_flag, tx_over_flag, multidrop_addr_detect_flag;
    logic [7:0]  rx_timeout_counter;
    logic        cts_s1, cts_s2, cts_s3, rx_s1, rx_s2;
    logic [3:0]  pre_cnt;
    logic [16:0] div_cnt;
    logic [7:0]  gap_cnt;
    logic [4:0]  brk_cnt;
    uai_pkg::uai_lin_st_t lin_st, next_lin_st;

    wire wr_isr  = wr_i && (addr_i == uai_pkg::ISR_OFS);
    wire wr_tor  = wr_i && (addr_i == uai_pkg::TOR_OFS);
    wire wr_baud = wr_i && (addr_i == uai_pkg::BAUD_OFS);
    wire wr_ircr = wr_i && (addr_i == uai_pkg::IRCR_OFS);
    wire wr_alt  = wr_i && (addr_i == uai_pkg::ALT_OFS);
    wire wr_fun  = wr_i && (addr_i == uai_pkg::FUN_OFS);
    wire wr_aux  = wr_i && (addr_i == uai_pkg::AUX_OFS);

    wire [7:0]  rx_timeout_compare = tor[7:0];
    wire [7:0]  tx_gap_delay       = tor[uai_pkg::TOR_DLY_LSB +: 8];
    wire [15:0] baud_divisor_value = baud[15:0];
    wire [3:0]  divider_x          = baud[uai_pkg::BAUD_X_LSB +: 4];
    wire        rx_invert          = ircr[uai_pkg::IRCR_INVRX];
    wire        tx_invert          = ircr[uai_pkg::IRCR_INVTX];
    wire [7:0]  addr_match         = alt[uai_pkg::ALT_MATCH_LSB +: 8];
    wire        multidrop_addr_detect_enable = alt[uai_pkg::ALT_ADDEN];
    wire        multidrop_auto_addr_detect   = alt[uai_pkg::ALT_AAD];
    wire        lin_tx_enable      = alt[uai_pkg::ALT_LINTX];
    wire [3:0]  lin_break_length   = alt[3:0];
    wire uai_pkg::uai_func_t func  = uai_pkg::uai_func_t'(fun[1:0]);

    // Line status is derived, so it drops as soon as its sources are gone
    wire rx_line_status_flag = line_i.brk | line_i.frame | line_i.parity
                             | multidrop_addr_detect_flag;
    wire buf_err_flag = tx_over_flag | line_i.rx_over;
    wire modem_flag   = cts_change_flag;
    wire [7:0] isr_flags = {lin_flag, 1'b0, buf_err_flag, tout_flag, modem_flag,
                            rx_line_status_flag, tx_hold_empty_flag, rx_avail_flag};
    wire [7:0] ien_vec = {ien_i.lin, 1'b0, ien_i.buf_err, ien_i.tout, ien_i.modem,
                          ien_i.rls, ien_i.thre, ien_i.rda};
    wire [7:0] isr_ind = isr_flags & ien_vec;

    // Prescaler runs M cycles, divisor stage BAUD_DIVISOR_VALUE+2 prescaler wraps
    wire [3:0] m_minus1 = !baud[uai_pkg::BAUD_XEN_BIT] ? uai_pkg::M_DEFAULT_M1 :
                          baud[uai_pkg::BAUD_XONE_BIT] ? 4'h0 : divider_x;
    wire [16:0] div_last = {1'b0, baud_divisor_value} + uai_pkg::BRD_ADD - 17'd1;
    wire pre_wrap = (pre_cnt >= m_minus1);
    // Compare with >= so a smaller divisor written mid-count cannot run away
    wire div_wrap = (div_cnt >= div_last);
    wire next_tick = pre_wrap && div_wrap;

    wire rx_nonempty   = (rx_count_i != '0);
    wire rx_activity   = evt_i.rx_push | evt_i.rx_pop | rx_buffer_port_rd_i;
    wire tout_set      = rx_nonempty && !rx_activity
                       && (rx_timeout_counter == rx_timeout_compare);
    wire tout_clr      = rx_buffer_port_rd_i | evt_i.rx_push | !rx_nonempty;
    wire rda_eq        = (rx_count_i == rx_trigger_level_i);
    wire rda_below     = (rx_count_i < rx_trigger_level_i);
    wire cts_changed   = cts_s2 ^ cts_s3;
    wire tx_over_set   = evt_i.tx_write && tx_fifo_full_i;
    wire addr_hit      = !multidrop_auto_addr_detect || (rx_addr_data_i == addr_match);
    wire addr_set      = evt_i.addr_char && (func == uai_pkg::UAI_FN_RS485)
                       && multidrop_addr_detect_enable && addr_hit;
    wire lin_send      = (lin_st == uai_pkg::UAI_LT_SEND);
    wire [4:0] brk_last = {1'b0, lin_break_length} + uai_pkg::LIN_BRK_ADD - 5'd1;
    wire brk_done      = lin_send && baud_tick_o && (brk_cnt == brk_last);

    always_comb begin
        next_lin_st = lin_st;
        case (lin_st)
            uai_pkg::UAI_LT_IDLE: begin
                if (lin_tx_enable) begin
                    next_lin_st = uai_pkg::UAI_LT_ALIGN;
                end
            end
            uai_pkg::UAI_LT_ALIGN: begin
                if (baud_tick_o) begin
                    next_lin_st = uai_pkg::UAI_LT_SEND;
                end
            end
            uai_pkg::UAI_LT_SEND: begin
                if (brk_done) begin
                    next_lin_st = uai_pkg::UAI_LT_IDLE;
                end
            end
            default: next_lin_st = uai_pkg::UAI_LT_IDLE;
        endcase
    end

    wire [7:0]  next_gap = evt_i.tx_stop_done ? tx_gap_delay :
                           (baud_tick_o && gap_cnt != 8'h00) ? gap_cnt - 8'h01 : gap_cnt;
    wire [31:0] aux_rd = {16'h0000, rx_timeout_counter, 5'h00,
                          multidrop_addr_detect_flag, tx_over_flag, cts_change_flag};
    wire [31:0] rd_mux = (addr_i == uai_pkg::ISR_OFS)  ? {16'h0000, isr_ind, isr_flags} :
                         (addr_i == uai_pkg::TOR_OFS)  ? tor  :
                         (addr_i == uai_pkg::BAUD_OFS) ? baud :
                         (addr_i == uai_pkg::IRCR_OFS) ? ircr :
                         (addr_i == uai_pkg::ALT_OFS)  ? alt  :
                         (addr_i == uai_pkg::FUN_OFS)  ? fun  :
                         (addr_i == uai_pkg::AUX_OFS)  ? aux_rd : 32'h00000000;

    // Configuration registers; masks keep reserved bits at zero
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tor  <= uai_pkg::TOR_RST;
            baud <= uai_pkg::BAUD_RST;
            ircr <= uai_pkg::IRCR_RST;
            fun  <= uai_pkg::FUN_RST;
        end else begin
            if (wr_tor)  tor  <= wdata_i & uai_pkg::TOR_MASK;
            if (wr_baud) baud <= wdata_i & uai_pkg::BAUD_MASK;
            if (wr_ircr) ircr <= wdata_i & uai_pkg::IRCR_MASK;
            if (wr_fun)  fun  <= wdata_i & uai_pkg::FUN_MASK;
        end
    end

    // A software write wins over the self-clear so a fresh request is never dropped
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            alt <= uai_pkg::ALT_RST;
        end else if (wr_alt) begin
            alt <= wdata_i & uai_pkg::ALT_MASK;
        end else if (brk_done) begin
            alt[uai_pkg::ALT_LINTX] <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 32'h00000000;
        end else begin
            rdata_o <= rd_i ? rd_mux : 32'h00000000;
        end
    end

    // Synchronisers; rx is taken from the second stage, clear-to-send change from the second and third
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // Idle level of the pin, so release of reset shows no false change
            cts_s1 <= 1'b1;
            cts_s2 <= 1'b1;
            cts_s3 <= 1'b1;
            rx_s1  <= 1'b1;
            rx_s2  <= 1'b1;
        end else begin
            cts_s1 <= cts_pin_i;
            cts_s2 <= cts_s1;
            cts_s3 <= cts_s2;
            rx_s1  <= rx_pin_i;
            rx_s2  <= rx_s1;
        end
    end

    // Sticky flags: set beats clear in the same cycle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lin_flag                   <= 1'b0;
            cts_change_flag            <= 1'b0;
            tx_over_flag               <= 1'b0;
            multidrop_addr_detect_flag <= 1'b0;
            tx_hold_empty_flag         <= uai_pkg::THRE_RST;
            rx_avail_flag              <= 1'b0;
            tout_flag                  <= 1'b0;
        end else begin
            lin_flag <= evt_i.lin_break_seen
                      | (lin_flag & ~(wr_isr & wdata_i[uai_pkg::ISR_LIN]));
            cts_change_flag <= cts_changed
                      | (cts_change_flag & ~(wr_aux & wdata_i[uai_pkg::AUX_CTS]));
            tx_over_flag <= tx_over_set
                      | (tx_over_flag & ~(wr_aux & wdata_i[uai_pkg::AUX_TXOVR]));
            multidrop_addr_detect_flag <= addr_set
                      | (multidrop_addr_detect_flag
                         & ~(wr_aux & wdata_i[uai_pkg::AUX_ADDR]));
            tx_hold_empty_flag <= evt_i.tx_last_moved
                      | (tx_hold_empty_flag & ~evt_i.tx_write);
            rx_avail_flag <= rda_eq | (rx_avail_flag & ~rda_below);
            tout_flag <= tout_set | (tout_flag & ~tout_clr);
        end
    end

    // Counter saturates so it cannot wrap and fire a second time
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_timeout_counter <= 8'h00;
        end else if (evt_i.rx_push) begin
            rx_timeout_counter <= 8'h00;
        end else if (baud_tick_o && rx_timeout_counter != 8'hff) begin
            rx_timeout_counter <= rx_timeout_counter + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pre_cnt     <= 4'h0;
            div_cnt     <= 17'h00000;
            baud_tick_o <= 1'b0;
        end else begin
            pre_cnt     <= pre_wrap ? 4'h0 : pre_cnt + 4'h1;
            baud_tick_o <= next_tick;
            if (pre_wrap) begin
                div_cnt <= div_wrap ? 17'h00000 : div_cnt + 17'h00001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lin_st  <= uai_pkg::UAI_LT_IDLE;
            brk_cnt <= 5'h00;
        end else begin
            lin_st <= next_lin_st;
            if (!lin_send) begin
                brk_cnt <= 5'h00;
            end else if (baud_tick_o) begin
                brk_cnt <= brk_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gap_cnt                      <= 8'h00;
            tx_gap_hold_o                <= 1'b0;
            tx_pin_o                     <= 1'b1;
            rx_serial_o                  <= 1'b1;
            irda_tx_enable_o             <= 1'b0;
            irda_rx_enable_o             <= 1'b0;
            controller_function_select_o <= 2'b00;
        end else begin
            gap_cnt       <= next_gap;
            tx_gap_hold_o <= (next_gap != 8'h00);
            tx_pin_o      <= (next_lin_st == uai_pkg::UAI_LT_SEND ? 1'b0 : tx_serial_i)
                             ^ tx_invert;
            rx_serial_o   <= rx_s2 ^ rx_invert;
            irda_tx_enable_o <= (func == uai_pkg::UAI_FN_IRDA) && ircr[uai_pkg::IRCR_TXSEL];
            irda_rx_enable_o <= (func == uai_pkg::UAI_FN_IRDA) && !ircr[uai_pkg::IRCR_TXSEL];
            controller_function_select_o <= fun[1:0];
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    logic [20:0] tick_gap;
    logic        cfg_dirty;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_gap  <= 21'h000000;
            cfg_dirty <= 1'b1;
        end else begin
            tick_gap  <= baud_tick_o ? 21'h000001 : tick_gap + 21'h000001;
            cfg_dirty <= wr_baud | (cfg_dirty & ~baud_tick_o);
        end
    end
    wire [20:0] exp_m      = {17'h00000, m_minus1} + 21'h000001;
    wire [20:0] exp_div    = {5'h00, baud_divisor_value} + 21'h000002;
    wire [41:0] exp_prod   = exp_m * exp_div;
    wire [20:0] exp_period = exp_prod[20:0];

    isr_ind_read_a: assert property (rd_i && addr_i == uai_pkg::ISR_OFS |=>
        rdata_o[15:8] == (rdata_o[7:0] & $past(ien_vec))) else $error("indicator not flag and enable");
    lin_flag_set_a: assert property (evt_i.lin_break_seen |=> isr_flags[7])
        else $error("LIN break flag not set");
    buf_err_ovf_a: assert property (tx_over_set |=> buf_err_flag && tx_over_flag)
        else $error("overflow did not raise buffer error");
    tout_clear_a: assert property (rx_buffer_port_rd_i |=> !tout_flag)
        else $error("time-out flag survived buffer read");
    tocnt_restart_a: assert property (evt_i.rx_push |=> rx_timeout_counter == 8'h00)
        else $error("time-out counter not restarted");
    cts_change_a: assert property ($changed(cts_pin_i) |-> ##[2:4] cts_change_flag)
        else $error("clear-to-send change missed");
    thre_set_a: assert property (evt_i.tx_last_moved |=> tx_hold_empty_flag)
        else $error("holding-empty flag not set");
    baud_period_a: assert property (baud_tick_o && !cfg_dirty && !$past(wr_baud)
        |-> tick_gap == exp_period) else $error("bit period wrong");
    break_level_a: assert property (lin_st == uai_pkg::UAI_LT_SEND && $past(lin_send)
        |-> tx_pin_o == tx_invert) else $error("break not driven as spacing");
    break_end_a: assert property (brk_done && !wr_alt |=> !lin_tx_enable)
        else $error("break enable not self-cleared");
    rda_eq_a: assert property (rda_eq |=> rx_avail_flag)
        else $error("receive-available flag not set");


    // Flag sets and clears, outputs and pin paths
    rls_line_a: assert property (line_i.brk |-> rx_line_status_flag)
        else $error("line status missed break");

    addr_flag_a: assert property (addr_set |=> multidrop_addr_detect_flag)
        else $error("address detect flag not set");

    func_out_a: assert property (1'b1 |=> controller_function_select_o == $past(fun[1:0]))
        else $error("function select output wrong");

    irda_dir_a: assert property (func == uai_pkg::UAI_FN_IRDA && ircr[1] |=> irda_tx_enable_o)
        else $error("IrDA transmit path not on");

    rx_inv_a: assert property (1'b1 |=> rx_serial_o == ($past(rx_s2) ^ $past(rx_invert)))
        else $error("receive path wrong");

    gap_load_a: assert property (evt_i.tx_stop_done && tx_gap_delay != 8'h00 |=> tx_gap_hold_o)
        else $error("gap hold not raised");

    thre_clear_a: assert property (evt_i.tx_write && !evt_i.tx_last_moved |=> !tx_hold_empty_flag)
        else $error("holding-empty flag not cleared");

    cts_clear_a: assert property (wr_aux && wdata_i[0] && !cts_changed |=> !cts_change_flag)
        else $error("clear-to-send change flag not cleared");

    lin_clear_a: assert property (wr_isr && wdata_i[7] && !evt_i.lin_break_seen |=> !lin_flag)
        else $error("LIN break flag not cleared");

    tout_fire_c: cover property (tout_set ##1 tout_flag);
    break_done_c: cover property (brk_done);
    baud_tick_c: cover property (baud_tick_o ##[1:40] baud_tick_o);
    addr_detect_c: cover property (addr_set ##1 rx_line_status_flag);
endmodule

`default_nettype wire

// ==== tb/uai_remote.sv ====
// Remote serial device model: drives the receive and clear-to-send pins of the block.
// Assumes the bench clock; lines idle high between frames.
`timescale 1ns/1ps
`default_nettype none
module uai_remote (
    input  wire logic clk_i,  // Bench clock
    input  wire logic tx_i,   // Line from the block
    output logic      rx_o,   // Line into the block
    output logic      cts_o   // Clear-to-send level
);
    initial begin
        rx_o  = 1'b1;
        cts_o = 1'b1;
    end
    // Pins are asynchronous, so change them away from the sampling edge
    task automatic toggle_cts();
        @(negedge clk_i);
        cts_o = ~cts_o;
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_uai_ctrl.sv ====
// Directed bench for uai_ctrl: register bus tasks, event pulses, pin checks.
// Assumes uai_pkg, uai_ctrl and uai_remote are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_uai_ctrl;
    logic               clk_i, reset_n_i, rx_pin_i, cts_pin_i, rx_serial_o, tx_pin_o;
    logic               baud_tick_o, irda_tx_enable_o, irda_rx_enable_o;
    logic               wr_i = 1'b0, rd_i = 1'b0, tx_fifo_full_i = 1'b0;
    logic               rx_buffer_port_rd_i = 1'b0, tx_serial_i = 1'b1;
    logic [7:0]         addr_i = 8'h00, rx_addr_data_i = 8'h00;
    logic [31:0]        wdata_i = 32'h0, rdata_o;
    logic [4:0]         rx_count_i = 5'h0, rx_trigger_level_i = 5'h1;
    logic [1:0]         controller_function_select_o;
    uai_pkg::uai_evt_t  evt_i = '0;
    uai_pkg::uai_line_t line_i = '0;
    uai_pkg::uai_ien_t  ien_i = '0;
    int                 error_cnt, n_compared, t;
    logic [7:0]         ra [7] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h00};
    logic [31:0]        rv [7] = '{32'h2, 32'h0, 32'h0f000000, 32'h40, 32'h0, 32'h0, 32'h0};
    logic [31:0]        rm [7] = '{32'h2, 32'hffff, 32'h3f00ffff, 32'h62, 32'h0, 32'h3, 32'h0};
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    uai_remote partner (.clk_i(clk_i), .tx_i(tx_pin_o), .rx_o(rx_pin_i), .cts_o(cts_pin_i));
    uai_ctrl #(.CNT_W(5)) DUT (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .evt_i, .line_i, .ien_i, .rx_count_i, .rx_trigger_level_i, .tx_fifo_full_i,
        .rx_buffer_port_rd_i, .rx_addr_data_i, .cts_pin_i, .rx_pin_i, .tx_serial_i,
        .rx_serial_o, .tx_pin_o, .baud_tick_o, .tx_gap_hold_o(), .irda_tx_enable_o,
        .irda_rx_enable_o, .controller_function_select_o);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o & m, e, "register read");
    endtask
    task automatic ev(input uai_pkg::uai_evt_t e);
        @(posedge clk_i);
        evt_i <= e;
        @(posedge clk_i);
        evt_i <= '0;
    endtask
    task automatic st();
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    task automatic tk(output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (baud_tick_o !== 1'b1 && n < 5000);
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #300us;
        error_cnt++;
        print_verdict();
    end
    initial begin
        reset_n_i = 1'b0;
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 7; i++) rd(ra[i], rv[i], 32'hffffffff);
        chk(rx_serial_o, 1'b0, "rx inverted at reset");
        for (int i = 0; i < 7; i++) if (i != 4) begin
            wr(ra[i], 32'hffffffff);
            rd(ra[i], rm[i], 32'hffffffff);
            wr(ra[i], rv[i]);
        end
        $display("test registers done");
        for (int f = 0; f < 4; f++) begin
            wr(8'h30, 32'(f));
            st();
            chk(controller_function_select_o, 32'(f), "function select");
        end
        wr(8'h30, 32'h2);
        wr(8'h28, 32'h2);
        st();
        chk({irda_tx_enable_o, irda_rx_enable_o}, 32'h2, "irda transmit path");
        wr(8'h28, 32'h0);
        st();
        chk({irda_tx_enable_o, irda_rx_enable_o}, 32'h1, "irda receive path");
        chk(rx_serial_o, 1'b1, "rx not inverted");
        wr(8'h28, 32'h20);
        st();
        chk(tx_pin_o, 1'b0, "tx inverted");
        wr(8'h28, 32'h0);
        $display("test modes done");
        ien_i <= 7'h22;
        rd(8'h1c, 32'h0202, 32'hffff);
        ev(7'h10);
        rd(8'h1c, 32'h0, 32'hffff);
        ev(7'h08);
        rd(8'h1c, 32'h0202, 32'hffff);
        tx_fifo_full_i <= 1'b1;
        ev(7'h10);
        tx_fifo_full_i <= 1'b0;
        rd(8'h1c, 32'h2020, 32'hffff);
        rd(8'h34, 32'h2, 32'h7);
        wr(8'h34, 32'h2);
        rd(8'h1c, 32'h0, 32'hffff);
        $display("test transmit flags done");
        ien_i <= 7'h48;
        partner.toggle_cts();
        st();
        rd(8'h1c, 32'h0808, 32'h0808);
        wr(8'h34, 32'h1);
        rd(8'h1c, 32'h0, 32'h0808);
        ev(7'h02);
        rd(8'h1c, 32'h8080, 32'h8080);
        wr(8'h1c, 32'h80);
        rd(8'h1c, 32'h0, 32'h8080);
        $display("test status flags done");
        wr(8'h24, 32'h28000001);
        tk(t);
        tk(t);
        chk(t, 27, "bit period");
        wr(8'h2c, 32'h81);
        t = 0;
        repeat (200) begin
            @(posedge clk_i);
            #1;
            if (tx_pin_o === 1'b0) t++;
        end
        chk(t, 81, "break length");
        rd(8'h2c, 32'h01, 32'hffffffff);
        $display("test baud and break done");
        wr(8'h20, 32'h28);
        ien_i <= 7'h11;
        rx_count_i <= 5'h1;
        ev(7'h40);
        repeat (36) @(posedge clk_i);
        rd(8'h1c, 32'h0101, 32'h1111);
        repeat (1150) @(posedge clk_i);
        rd(8'h1c, 32'h1111, 32'h1111);
        @(posedge clk_i);
        rx_buffer_port_rd_i <= 1'b1;
        @(posedge clk_i);
        rx_buffer_port_rd_i <= 1'b0;
        rd(8'h1c, 32'h0101, 32'h1111);
        rx_count_i <= 5'h0;
        rd(8'h1c, 32'h0, 32'h1111);
        $display("test time-out done");
        wr(8'h30, 32'h3);
        wr(8'h2c, 32'h5a008200);
        rx_addr_data_i <= 8'h5a;
        ien_i <= 7'h04;
        ev(7'h01);
        rd(8'h1c, 32'h0404, 32'h0404);
        rd(8'h34, 32'h4, 32'h4);
        $display("test address detect done");
        print_verdict();
    end
endmodule
`default_nettype wire
